/* hdl/two_wire_target_port.v */
`timescale 1ns/1ps
`include "two_wire_target_port_regs.vh"
module two_wire_target_port (
  input  wire        clock,
  input  wire        nrst,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bus_addr_valid,
  input  wire [6:0]  bus_addr,
  input  wire        bus_dir_read,
  input  wire        bus_byte_valid,
  input  wire [7:0]  bus_byte,
  input  wire        bus_stop,
  output reg         bus_ack,
  output reg  [7:0]  bus_send_byte,
  input  wire        ctrl_start,
  input  wire        ctrl_done,
  input  wire [1:0]  ctrl_error,
  output reg  [6:0]  ctrl_target_address,
  output reg         ctrl_direction_is_read,
  output reg         ctrl_addr_load,
  output wire        irq
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Every bus and controller pin crosses two flops before any logic reads it. Strobes and
  // the data they qualify travel side by side; the far side holds its
  // data steady while the strobe is high.
  reg  [4:0]  strobe_sync1;
  reg  [4:0]  strobe_sync2;
  reg  [17:0] data_sync1;
  reg  [17:0] data_sync2;
  wire [4:0]  strobe_pins;
  wire [17:0] data_pins;

  assign strobe_pins = {bus_addr_valid, bus_byte_valid, bus_stop, ctrl_start,
                        ctrl_done};
  assign data_pins   = {bus_addr, bus_dir_read, bus_byte, ctrl_error};

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobe_sync1 <= 5'h0;
      strobe_sync2 <= 5'h0;
    end else begin
      strobe_sync1 <= strobe_pins;
      strobe_sync2 <= strobe_sync1;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_sync1 <= 18'h0;
      data_sync2 <= 18'h0;
    end else begin
      data_sync1 <= data_pins;
      data_sync2 <= data_sync1;
    end
  end

  wire       s_addr_valid = strobe_sync2[4];
  wire       s_byte_valid = strobe_sync2[3];
  wire       s_stop       = strobe_sync2[2];
  wire       s_start      = strobe_sync2[1];
  wire       s_done       = strobe_sync2[0];
  wire [6:0] s_addr       = data_sync2[17:11];
  wire       s_dir_read   = data_sync2[10];
  wire [7:0] s_byte       = data_sync2[9:2];
  wire [1:0] s_err        = data_sync2[1:0];

  // Edge detection on synchronised strobes
  // Idle pins are low, so zero reset values give no false edge
  reg  prev_addr;
  reg  prev_byte;
  reg  prev_start;
  reg  prev_done;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_addr  <= 1'b0;
      prev_byte  <= 1'b0;
      prev_start <= 1'b0;
      prev_done  <= 1'b0;
    end else begin
      prev_addr  <= s_addr_valid;
      prev_byte  <= s_byte_valid;
      prev_start <= s_start;
      prev_done  <= s_done;
    end
  end
  wire addr_ev  = s_addr_valid & ~prev_addr;
  wire byte_ev  = s_byte_valid & ~prev_byte;
  wire start_ev = s_start & ~prev_start;
  wire done_ev  = s_done & ~prev_done;

  // ==========================================================
  // Registers
  // ==========================================================
  reg  [6:0] own_or_target_address;
  reg        direction_is_read;
  reg        target_enable;
  reg        masked_select;
  reg        ctrl_masked_select;
  reg  [6:0] own_addr;
  reg  [1:0] action;
  reg  [7:0] rx_data;
  reg        selected;
  reg        first_pending;
  reg        tgt_raw;
  reg        tgt_mask;
  reg        ctrl_raw;
  reg        ctrl_mask;
  reg  [1:0] ctrl_err_state;

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  reg        aw_held;
  reg        w_held;
  reg  [7:0] aw_ofs;
  reg [31:0] w_data;
  reg  [3:0] w_strb;

  // One write at a time: address and data are refused until answered
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire do_read  = s_axi_arvalid & s_axi_arready;
  wire [7:0] ar_ofs = s_axi_araddr[7:0];

  function known;
    input [7:0] ofs;
    begin
      known = (ofs == `OFS_CTRL_ADDR) || (ofs == `OFS_CTRL_STATUS) ||
              (ofs == `OFS_CTRL_INT) || (ofs == `OFS_TGT_CTRL) ||
              (ofs == `OFS_TGT_STATUS) || (ofs == `OFS_TGT_DATA) ||
              (ofs == `OFS_TGT_INT) || (ofs == `OFS_TGT_INT_MASK);
    end
  endfunction

  // Write enable of one register byte lane
  function write_hit;
    input       go;
    input [7:0] ofs;
    input [7:0] want;
    input       lane;
    begin
      write_hit = go & (ofs == want) & lane;
    end
  endfunction

  wire wr_ctrl_addr = write_hit(do_write, aw_ofs, `OFS_CTRL_ADDR,
                                w_strb[0]);
  wire wr_ctrl_int  = write_hit(do_write, aw_ofs, `OFS_CTRL_INT,
                                w_strb[0]);
  wire wr_tgt_ctrl  = write_hit(do_write, aw_ofs, `OFS_TGT_CTRL,
                                w_strb[0]);
  wire wr_own_addr  = write_hit(do_write, aw_ofs, `OFS_TGT_CTRL,
                                w_strb[1]);
  wire wr_tgt_data  = write_hit(do_write, aw_ofs, `OFS_TGT_DATA,
                                w_strb[0]);
  wire wr_tgt_int   = write_hit(do_write, aw_ofs, `OFS_TGT_INT,
                                w_strb[0]);
  wire wr_tgt_mask  = write_hit(do_write, aw_ofs, `OFS_TGT_INT_MASK,
                                w_strb[0]);
  wire rd_tgt_data  = do_read & (ar_ofs == `OFS_TGT_DATA);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_ofs       <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_ofs  <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(aw_ofs) ? 2'h0 : 2'h2;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is chosen here and registered when the address is taken
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (ar_ofs)
      `OFS_CTRL_ADDR:
        next_rdata = {24'h000000, own_or_target_address, direction_is_read};
      `OFS_CTRL_STATUS:
        next_rdata = {28'h0000000, ctrl_err_state, 2'h0}; // RULE16
      `OFS_CTRL_INT:
        next_rdata = {29'h0000000, ctrl_masked_select, ctrl_mask,
                      ctrl_masked_select ? (ctrl_raw & ctrl_mask)
                                         : ctrl_raw}; // RULE2
      `OFS_TGT_CTRL:
        next_rdata = {17'h00000, own_addr, 6'h00, masked_select,
                      target_enable};
      `OFS_TGT_STATUS:
        next_rdata = {30'h0000000, action}; // RULE18
      `OFS_TGT_DATA:
        next_rdata = {24'h000000, rx_data}; // RULE8
      `OFS_TGT_INT:
        next_rdata = {30'h0000000, tgt_raw,
                      masked_select ? (tgt_raw & tgt_mask)
                                    : tgt_raw}; // RULE15
      `OFS_TGT_INT_MASK:
        next_rdata = {31'h0000000, tgt_mask};
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known(ar_ofs) ? 2'h0 : 2'h2;
      s_axi_rdata  <= next_rdata;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Controller side
  // ==========================================================
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      own_or_target_address  <= `RST_OWN_ADDR;
      direction_is_read      <= 1'b0;
      ctrl_target_address    <= `RST_OWN_ADDR;
      ctrl_direction_is_read <= 1'b0;
      ctrl_addr_load         <= 1'b0;
      ctrl_raw               <= 1'b0;
      ctrl_mask              <= 1'b0;
      ctrl_masked_select     <= 1'b0;
      ctrl_err_state         <= `ERR_NONE;
    end else begin
      ctrl_addr_load <= 1'b0;
      if (wr_ctrl_addr) begin
        own_or_target_address <= w_data[7:1];
        direction_is_read     <= w_data[0];
      end
      // Copied at start so software may stage the next address
      if (start_ev) begin
        ctrl_target_address    <= own_or_target_address; // RULE1
        ctrl_direction_is_read <= direction_is_read; // RULE1
        ctrl_addr_load         <= 1'b1;
      end
      if (wr_ctrl_int) begin
        ctrl_mask          <= w_data[1];
        ctrl_masked_select <= w_data[2];
      end
      // Error code comes from the same flop stage as the done strobe
      if (done_ev) begin
        ctrl_raw       <= 1'b1;
        ctrl_err_state <= s_err; // RULE16
      end else if (wr_ctrl_int & w_data[0])
        ctrl_raw <= 1'b0;
    end
  end

  // ==========================================================
  // Target side
  // ==========================================================
  wire match = target_enable & addr_ev & (s_addr == own_addr); // RULE3 RULE11

  // Software settings of the target
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      target_enable <= 1'b0;
      masked_select <= 1'b0;
      own_addr      <= `RST_OWN_ADDR;
      tgt_mask      <= 1'b0;
      bus_send_byte <= 8'h00;
    end else begin
      if (wr_tgt_ctrl) begin
        target_enable <= w_data[`BIT_TGT_EN];
        masked_select <= w_data[`BIT_MASKED_SEL];
      end
      if (wr_own_addr)
        own_addr <= w_data[14:8];
      if (wr_tgt_mask)
        tgt_mask <= w_data[0]; // RULE13 RULE14
      if (wr_tgt_data)
        bus_send_byte <= w_data[7:0]; // RULE9
    end
  end

  // Selection, received data and pending action
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      action        <= `ACT_IDLE;
      rx_data       <= 8'h00;
      bus_ack       <= 1'b0;
      selected      <= 1'b0;
      first_pending <= 1'b0;
    end else if (!target_enable) begin
      selected <= 1'b0; // RULE10
      bus_ack  <= 1'b0; // RULE10
      action   <= `ACT_IDLE; // RULE4
    end else begin
      // Data access acknowledges; a bus event in the same cycle wins
      if (rd_tgt_data | wr_tgt_data)
        action <= `ACT_IDLE; // RULE18 RULE4
      if (match) begin
        selected      <= 1'b1;
        bus_ack       <= 1'b1;
        first_pending <= ~s_dir_read;
        if (s_dir_read)
          action <= `ACT_TX; // RULE6
      end else if (addr_ev) begin
        selected <= 1'b0;
        bus_ack  <= 1'b0;
      end
      if (byte_ev & selected) begin
        rx_data       <= s_byte; // RULE8
        first_pending <= 1'b0;
        action <= first_pending ? `ACT_RX_FIRST : `ACT_RX; // RULE7 RULE5
      end
      if (s_stop) begin
        selected <= 1'b0;
        bus_ack  <= 1'b0;
      end
    end
  end

  // Raw flag sets whatever the mask, and a set beats a same-cycle clear
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      tgt_raw <= 1'b0;
    else if (target_enable & (match | (byte_ev & selected)))
      tgt_raw <= 1'b1; // RULE17
    else if (wr_tgt_int & w_data[0])
      tgt_raw <= 1'b0; // RULE12
  end

  // Level interrupt, high while an unmasked source is pending
  assign irq = (tgt_raw & tgt_mask) | (ctrl_raw & ctrl_mask); // RULE17 RULE13

endmodule // two_wire_target_port

/* hdl/two_wire_target_port_regs.vh */
// Functional notes
// (RULE1) Controller start drives programmed 7-bit address, direction read if flag set.
// (RULE2) Controller interrupt status readable raw or masked as one bit.
// (RULE3) Target holds 7-bit own address, answers only a matching address.
// (RULE4) Target status shows idle code when nothing is requested.
// (RULE5) Target status shows byte-received code when written byte waits.
// (RULE6) Target status shows send-requested code on a read request.
// (RULE7) First byte after own address shows a distinct code.
// (RULE8) Reading target data returns last received byte in low eight bits.
// (RULE9) Writing target data loads byte sent on next read request.
// (RULE10) Target disabled: no matching, no acknowledge, no transfer.
// (RULE11) Target enabled: takes part using programmed own address.
// (RULE12) Clearing target interrupt deasserts the pending interrupt.
// (RULE13) Target interrupt enable lets pending interrupt reach the line.
// (RULE14) Disabling target interrupt blocks line, keeps raw pending state.
// (RULE15) Target interrupt status readable raw or masked as one bit.
// (RULE16) Controller reports none, address nack, data nack or arbitration lost.
// (RULE17) Masked status is raw AND enable; raw sets regardless of enable.
// (RULE18) Status reads have no side effect; data access acknowledges action.
`ifndef TWO_WIRE_TARGET_PORT_REGS_VH
`define TWO_WIRE_TARGET_PORT_REGS_VH
`define OFS_CTRL_ADDR    8'h00
`define OFS_CTRL_STATUS  8'h04
`define OFS_CTRL_INT     8'h08
`define OFS_TGT_CTRL     8'h10
`define OFS_TGT_STATUS   8'h14
`define OFS_TGT_DATA     8'h18
`define OFS_TGT_INT      8'h1C
`define OFS_TGT_INT_MASK 8'h20
`define ACT_IDLE         2'h0
`define ACT_RX           2'h1
`define ACT_TX           2'h2
`define ACT_RX_FIRST     2'h3
`define ERR_NONE         2'h0
`define ERR_ADDR_ACK     2'h1
`define ERR_DATA_ACK     2'h2
`define ERR_ARB_LOST     2'h3
`define BIT_TGT_EN       0
`define BIT_MASKED_SEL   1
`define RST_OWN_ADDR     7'h00
`endif

/* verification/two_wire_target_port_checker.sv */
`timescale 1ns/1ps
module two_wire_target_port_checker (
  input wire       clock,
  input wire       nrst,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       bus_addr_valid,
  input wire       bus_stop,
  input wire       bus_ack,
  input wire       ctrl_start,
  input wire [6:0] ctrl_target_address,
  input wire       ctrl_direction_is_read,
  input wire       ctrl_addr_load
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // =====================================
  // Register bus
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after take");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  // =====================================
  // Controller address and target select
  a_load_pulse: assert property (ctrl_addr_load |=> !ctrl_addr_load)
    else $error("address load longer than one cycle");
  a_start_load: assert property ($rose(ctrl_start) |-> ##[1:5] ctrl_addr_load)
    else $error("start did not load address");
  a_addr_latched: assert property ($changed({ctrl_target_address, ctrl_direction_is_read}) |-> ctrl_addr_load)
    else $error("address changed without load");
  a_ack_needs_addr: assert property ($rose(bus_ack) |-> bus_addr_valid && !bus_stop)
    else $error("ack without address phase");
  a_ack_stop: assert property ($rose(bus_stop) |-> ##[1:5] !bus_ack)
    else $error("ack held after stop");
endmodule // two_wire_target_port_checker
bind two_wire_target_port two_wire_target_port_checker chk (.*);

/* verification/bus_controller_model.sv */
`timescale 1ns/1ps
module bus_controller_model (
  input  wire       clock,
  output reg        bus_addr_valid,
  output reg  [6:0] bus_addr,
  output reg        bus_dir_read,
  output reg        bus_byte_valid,
  output reg  [7:0] bus_byte,
  output reg        bus_stop,
  output reg        ctrl_done,
  output reg  [1:0] ctrl_error
);
  initial begin
    {bus_addr_valid, bus_byte_valid, bus_stop, ctrl_done} = 4'h0;
    {bus_addr, bus_dir_read, bus_byte, ctrl_error} = 18'h00000;
  end
  task automatic select(input [6:0] a, input rd);
    @(posedge clock);
    bus_addr <= a;
    bus_dir_read <= rd;
    bus_addr_valid <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  task automatic put_byte(input [7:0] b);
    @(posedge clock);
    bus_byte <= b;
    bus_byte_valid <= 1'b1;
    repeat (3) @(posedge clock);
    bus_byte_valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // Released address and byte lines show the inverse of their last value
  task automatic stop;
    @(posedge clock);
    bus_addr_valid <= 1'b0;
    bus_stop <= 1'b1;
    bus_addr <= ~bus_addr;
    bus_byte <= ~bus_byte;
    repeat (6) @(posedge clock);
    bus_stop <= 1'b0;
  endtask
  task automatic finish_xfer(input [1:0] e);
    @(posedge clock);
    ctrl_error <= e;
    ctrl_done <= 1'b1;
    repeat (4) @(posedge clock);
    ctrl_done <= 1'b0;
    ctrl_error <= ~e;
    repeat (3) @(posedge clock);
  endtask
endmodule // bus_controller_model

/* verification/tb.sv */
`timescale 1ns/1ps
`include "two_wire_target_port_regs.vh"
module tb;
  logic        clock, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, ctrl_start;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ctrl_error;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, bus_addr_valid, bus_dir_read, bus_byte_valid;
  logic        bus_stop, bus_ack, ctrl_done, ctrl_direction_is_read;
  logic        ctrl_addr_load, irq;
  logic [6:0]  bus_addr, ctrl_target_address;
  logic [7:0]  bus_byte, bus_send_byte;
  logic [31:0] rd;
  logic [1:0]  rr, br;
  int          err_count = 0;
  int          cmp_count = 0;
  two_wire_target_port dut (.*);
  bus_controller_model bfm (.*);
  always #2.5 clock = ~clock;
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdchk(input [7:0] a, input [31:0] e);
    @(posedge clock);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd, e);
  endtask
  task automatic start_ctrl;
    @(posedge clock);
    ctrl_start <= 1'b1;
    repeat (6) @(posedge clock);
    ctrl_start <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    {clock, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, ctrl_start} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rdchk(`OFS_TGT_STATUS, {30'h0, `ACT_IDLE});
    rdchk(8'h40, 32'h00000000);
    chk({30'h0, rr}, 32'h00000002);
    wr(8'h44, 32'h00000000);
    chk({30'h0, br}, 32'h00000002);
    $display("test reset done");
    wr(`OFS_TGT_CTRL, 32'h00002A01);
    wr(`OFS_TGT_INT_MASK, 32'h00000001);
    chk({30'h0, br}, 32'h00000000);
    bfm.select(7'h15, 1'b0);
    chk(bus_ack, 1'b0);
    bfm.stop();
    bfm.select(7'h2A, 1'b0);
    chk(bus_ack, 1'b1);
    bfm.put_byte(8'hA5);
    rdchk(`OFS_TGT_STATUS, {30'h0, `ACT_RX_FIRST});
    chk(irq, 1'b1);
    rdchk(`OFS_TGT_DATA, 32'h000000A5);
    rdchk(`OFS_TGT_STATUS, {30'h0, `ACT_IDLE});
    bfm.put_byte(8'h5C);
    rdchk(`OFS_TGT_STATUS, {30'h0, `ACT_RX});
    bfm.stop();
    rdchk(`OFS_TGT_INT, 32'h00000003);
    wr(`OFS_TGT_INT_MASK, 32'h00000000);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    rdchk(`OFS_TGT_INT, 32'h00000003);
    wr(`OFS_TGT_CTRL, 32'h00002A03);
    rdchk(`OFS_TGT_INT, 32'h00000002);
    wr(`OFS_TGT_INT, 32'h00000001);
    rdchk(`OFS_TGT_INT, 32'h00000000);
    $display("test receive done");
    wr(`OFS_TGT_DATA, 32'h0000003C);
    bfm.select(7'h2A, 1'b1);
    rdchk(`OFS_TGT_STATUS, {30'h0, `ACT_TX});
    chk(bus_send_byte, 8'h3C);
    wr(`OFS_TGT_DATA, 32'h000000C3);
    chk(bus_send_byte, 8'hC3);
    bfm.stop();
    wr(`OFS_TGT_CTRL, 32'h00002A00);
    bfm.select(7'h2A, 1'b0);
    chk(bus_ack, 1'b0);
    bfm.put_byte(8'h77);
    rdchk(`OFS_TGT_STATUS, {30'h0, `ACT_IDLE});
    rdchk(`OFS_TGT_DATA, 32'h0000005C);
    bfm.stop();
    $display("test send and disable done");
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_CTRL_ADDR, {24'h000000, 7'h55 ^ 7'(i), ~1'(i)});
      start_ctrl();
      chk(ctrl_target_address, 7'h55 ^ 7'(i));
      chk(ctrl_direction_is_read, {31'h0, ~1'(i)});
    end
    wr(`OFS_CTRL_INT, 32'h00000002);
    for (int e = 0; e < 4; e++) begin
      bfm.finish_xfer(2'(e));
      rdchk(`OFS_CTRL_STATUS, 32'(e) << 2);
    end
    rdchk(`OFS_CTRL_INT, 32'h00000003);
    chk(irq, 1'b1);
    wr(`OFS_CTRL_INT, 32'h00000004);
    rdchk(`OFS_CTRL_INT, 32'h00000004);
    chk(irq, 1'b0);
    wr(`OFS_CTRL_INT, 32'h00000001);
    rdchk(`OFS_CTRL_INT, 32'h00000000);
    $display("test controller done");
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end
endmodule // tb
